// ==== pkg/tki_pkg.sv ====
package tki_pkg;
   // Bus address field of the internal address register
   localparam logic [7:0] ADDR_REG_OFFSET  = 8'h07;
   localparam int         ADDR_FIELD_LSB   = 1;
   localparam logic [6:0] ADDR_RESET       = 7'h10;
   localparam int         MEM_DEPTH        = 16;
   // Bit counts per phase
   localparam int         PHASE_BITS       = 9;
   localparam int         ADDR_BITS        = 7;
   // Host timing
   localparam int         CLK_MHZ          = 100;
   localparam int         SCL_RATE_KHZ     = 100;
   localparam int         SCL_HALF_CYCLES  =
      (CLK_MHZ * 1000) / (SCL_RATE_KHZ * 2);
   localparam int         REPLY_WAIT_US    = 50;
   localparam int         REPLY_WAIT_CYCLES = REPLY_WAIT_US * CLK_MHZ;
   // Host APB register map
   localparam logic [7:0] REG_CTRL   = 8'h00;
   localparam logic [7:0] REG_TXDATA = 8'h04;
   localparam logic [7:0] REG_STATUS = 8'h08;
   localparam logic [7:0] REG_RXDATA = 8'h0c;
   // Host command codes
   typedef enum logic [1:0] {
      TKI_CMD_START = 2'b00,
      TKI_CMD_WRITE = 2'b01,
      TKI_CMD_READ  = 2'b10,
      TKI_CMD_STOP  = 2'b11
   } tki_cmd_t;
endpackage : tki_pkg

// ==== pkg/tki_if.sv ====
`timescale 1ns/1ns
interface tki_if;
   logic scl_o;
   logic scl_oe;
   logic sda_host_o;
   logic sda_host_oe;
   logic sda_dev_o;
   logic sda_dev_oe;
   logic sel2_level;
   logic data_request_n;
   logic scl;
   logic sda;
   // Open-drain wired-and with pull-ups
   assign scl = scl_oe ? scl_o : 1'b1;
   assign sda = (sda_host_oe && !sda_host_o) || (sda_dev_oe && !sda_dev_o)
                ? 1'b0 : 1'b1;
   modport device (
      input  scl,
      input  sda,
      input  sel2_level,
      output sda_dev_o,
      output sda_dev_oe,
      output data_request_n
   );
   modport host (
      input  sda,
      input  data_request_n,
      output scl_o,
      output scl_oe,
      output sda_host_o,
      output sda_host_oe,
      output sel2_level
   );
endinterface : tki_if

// ==== hw/tki_device.sv ====
`timescale 1ns/1ns
// Function
// - Address phase: seven bits, direction, acknowledge
// - Acknowledge own address in ninth cycle
// - Data phase: byte plus acknowledge
// - Receiver acknowledges low; high means not-acknowledge
// - Host ends every transfer with STOP
// - Direction 0 writes, 1 reads; ignore others
// - Seven-bit address resets to 0x10
// - Address taken from register seven bits 7:1
// - Host drives clock; device only samples
// - Host grounds select2, pulls others high
// - Sample select pins at power-on; direct_mode_sel follows them every cycle while the mode pin is high
// - Select0 pin becomes serial clock input
// - Write carries memory offset then data
// - Host acknowledges reads, nacks last byte
// - Host waits 50 us before reading reply
// - Request low on button change, high after the host ack bit of a read byte
// - Request high means idle, ready for command
// - Standard-mode rate only, up to 100 kbit/s
// - Mode pin low protocol, high direct I/O
// - Direct I/O: select pins choose mode
// - Upper button pins sense or show status
// - Power-save low sleeps, high resumes
module tki_device #(
   parameter int NBTN = 9
) (
   input  wire logic            pclk,
   input  wire logic            presetn,
   tki_if.device                bus,
   input  wire logic            io_protocol_select,
   input  wire logic            power_save_n,
   input  wire logic [NBTN-1:0] sense_button_pins,
   input  wire logic [NBTN-1:0] upper_button_in,
   output logic      [NBTN-1:0] shared_button_output_pins,
   output logic                 upper_as_output,
   output logic                 two_wire_selected,
   output logic                 sleeping,
   output logic      [2:0]      direct_mode_sel
);
   typedef enum logic [2:0] {
      TKI_D_IDLE = 3'b000,
      TKI_D_ADDR = 3'b001,
      TKI_D_AACK = 3'b010,
      TKI_D_WBYT = 3'b011,
      TKI_D_WACK = 3'b100,
      TKI_D_RBYT = 3'b101,
      TKI_D_RACK = 3'b110,
      TKI_D_WAIT = 3'b111
   } tki_dstate_t;

   ////////////////////////////////////////////////////////////////////
   // Pin synchronisers
   logic [1:0] scl_s_q, sda_s_q, mode_s_q, ps_s_q, sel2_s_q;
   logic       scl_q, sda_q;
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         scl_s_q  <= 2'b11;
         sda_s_q  <= 2'b11;
         mode_s_q <= 2'b00;
         ps_s_q   <= 2'b11;
         sel2_s_q <= 2'b00;
         scl_q    <= 1'b1;
         sda_q    <= 1'b1;
      end else begin
         scl_s_q  <= {scl_s_q[0], bus.scl};
         sda_s_q  <= {sda_s_q[0], bus.sda};
         mode_s_q <= {mode_s_q[0], io_protocol_select};
         ps_s_q   <= {ps_s_q[0], power_save_n};
         sel2_s_q <= {sel2_s_q[0], bus.sel2_level};
         scl_q    <= scl_s_q[1];
         sda_q    <= sda_s_q[1];
      end
   end
   logic scl_rise, scl_fall, start_ev, stop_ev;
   assign scl_rise = scl_s_q[1] && !scl_q;
   assign scl_fall = !scl_s_q[1] && scl_q;
   assign start_ev = scl_s_q[1] && scl_q && sda_q && !sda_s_q[1];
   assign stop_ev  = scl_s_q[1] && scl_q && !sda_q && sda_s_q[1];

   ////////////////////////////////////////////////////////////////////
   // Power-on strap capture
   logic       strap_done_q;
   logic [1:0] strap_cnt_q;
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         strap_cnt_q       <= 2'd0;
         strap_done_q      <= 1'b0;
         two_wire_selected <= 1'b0;
         upper_as_output   <= 1'b0;
         direct_mode_sel   <= 3'b000;
      end else begin
         // Wait until the pin synchronisers hold real strap levels
         if (strap_cnt_q != 2'd2) begin
            strap_cnt_q <= strap_cnt_q + 2'd1;
         end
         if (!strap_done_q && strap_cnt_q == 2'd2) begin
            strap_done_q      <= 1'b1;
            two_wire_selected <= !mode_s_q[1] && !sel2_s_q[1];
            upper_as_output   <= mode_s_q[1];
         end
         if (mode_s_q[1]) begin
            direct_mode_sel <= {sel2_s_q[1], sda_s_q[1], scl_s_q[1]};
         end
      end
   end
   logic active;
   assign active = strap_done_q && two_wire_selected;

   ////////////////////////////////////////////////////////////////////
   // Sleep control and button change detect
   logic [2*NBTN-1:0] btn_s1_q, btn_s2_q, btn_last_q;
   logic            pend_q;
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         sleeping   <= 1'b0;
         btn_s1_q   <= '0;
         btn_s2_q   <= '0;
         btn_last_q <= '0;
         shared_button_output_pins <= '0;
      end else begin
         sleeping <= !ps_s_q[1];
         // Upper pins sense only while they are not status outputs
         btn_s1_q <= {(upper_as_output ? '0 : upper_button_in),
                      sense_button_pins};
         btn_s2_q <= btn_s1_q;
         if (!sleeping) begin
            btn_last_q <= btn_s2_q;
         end
         shared_button_output_pins <= upper_as_output ? btn_last_q[NBTN-1:0]
                                                      : '0;
      end
   end
   logic btn_change;
   assign btn_change = !sleeping && (btn_s2_q != btn_last_q);

   ////////////////////////////////////////////////////////////////////
   // Serial engine
   tki_dstate_t     st_q;
   logic [7:0]      sh_q;
   logic [3:0]      cnt_q;
   logic            rd_q, have_off_q, drive_low_q;
   logic [7:0]      off_q;
   logic [7:0]      mem_q [tki_pkg::MEM_DEPTH];
   logic [6:0]      own_addr;
   logic            read_done;
   localparam int ADDR_IDX = int'(tki_pkg::ADDR_REG_OFFSET);
   assign own_addr = mem_q[ADDR_IDX][7:tki_pkg::ADDR_FIELD_LSB];
   assign read_done = (st_q == TKI_D_RACK) && scl_rise;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         st_q        <= TKI_D_IDLE;
         sh_q        <= 8'h00;
         cnt_q       <= 4'h0;
         rd_q        <= 1'b0;
         have_off_q  <= 1'b0;
         off_q       <= 8'h00;
         drive_low_q <= 1'b0;
         for (int i = 0; i < tki_pkg::MEM_DEPTH; i++) begin
            mem_q[i] <= 8'h00;
         end
         mem_q[ADDR_IDX] <= {tki_pkg::ADDR_RESET, 1'b0};
      end else begin
         mem_q[0] <= btn_last_q[7:0];
         if (!active || stop_ev) begin
            st_q        <= TKI_D_IDLE;
            drive_low_q <= 1'b0;
         end else if (start_ev) begin
            st_q        <= TKI_D_ADDR;
            cnt_q       <= 4'h0;
            have_off_q  <= 1'b0;
            drive_low_q <= 1'b0;
         end else begin
            case (st_q)
               TKI_D_ADDR: begin
                  if (scl_rise) begin
                     sh_q  <= {sh_q[6:0], sda_q};
                     cnt_q <= cnt_q + 4'h1;
                  end else if (scl_fall && cnt_q == 4'd8) begin
                     if (sh_q[7:1] == own_addr) begin
                        rd_q        <= sh_q[0];
                        drive_low_q <= 1'b1;
                        st_q        <= TKI_D_AACK;
                     end else begin
                        st_q <= TKI_D_WAIT;
                     end
                  end
               end
               TKI_D_AACK, TKI_D_WACK: begin
                  if (scl_fall) begin
                     cnt_q <= 4'h0;
                     if (rd_q) begin
                        sh_q        <= mem_q[off_q[3:0]];
                        drive_low_q <= !mem_q[off_q[3:0]][7];
                        off_q       <= off_q + 8'h01;
                        st_q        <= TKI_D_RBYT;
                     end else begin
                        drive_low_q <= 1'b0;
                        st_q        <= TKI_D_WBYT;
                     end
                  end
               end
               TKI_D_WBYT: begin
                  if (scl_rise) begin
                     sh_q  <= {sh_q[6:0], sda_q};
                     cnt_q <= cnt_q + 4'h1;
                  end else if (scl_fall && cnt_q == 4'd8) begin
                     drive_low_q <= 1'b1;
                     st_q        <= TKI_D_WACK;
                     if (!have_off_q) begin
                        off_q      <= sh_q;
                        have_off_q <= 1'b1;
                     end else begin
                        mem_q[off_q[3:0]] <= sh_q;
                        off_q <= off_q + 8'h01;
                     end
                  end
               end
               TKI_D_RBYT: begin
                  if (scl_fall) begin
                     cnt_q <= cnt_q + 4'h1;
                     if (cnt_q == 4'd7) begin
                        drive_low_q <= 1'b0;
                        st_q        <= TKI_D_RACK;
                     end else begin
                        sh_q        <= {sh_q[6:0], 1'b0};
                        drive_low_q <= !sh_q[6];
                     end
                  end
               end
               TKI_D_RACK: begin
                  if (scl_rise) begin
                     // Acknowledge continues, high releases
                     st_q <= sda_q ? TKI_D_WAIT : TKI_D_AACK;
                  end
               end
               default: begin
                  drive_low_q <= 1'b0;
               end
            endcase
         end
      end
   end
   assign bus.sda_dev_o  = 1'b0;
   assign bus.sda_dev_oe = drive_low_q;

   ////////////////////////////////////////////////////////////////////
   // Data request line
   logic req_n_q;
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         req_n_q <= 1'b1;
      end else if (btn_change) begin
         req_n_q <= 1'b0;
      end else if (read_done) begin
         req_n_q <= 1'b1;
      end
   end
   assign bus.data_request_n = req_n_q;
endmodule : tki_device

// ==== hw/tki_host.sv ====
`timescale 1ns/1ns
module tki_host (
   input  wire logic        pclk,
   input  wire logic        presetn,
   tki_if.host              bus,
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [7:0]  paddr,
   input  wire logic [31:0] pwdata,
   output logic      [31:0] prdata,
   output logic             pready,
   output logic             pslverr
);
   typedef enum logic [2:0] {
      TKI_H_IDLE = 3'b000,
      TKI_H_STA  = 3'b001,
      TKI_H_BITL = 3'b010,
      TKI_H_BITH = 3'b011,
      TKI_H_STO  = 3'b100,
      TKI_H_WAIT = 3'b101
   } tki_hstate_t;

   ////////////////////////////////////////////////////////////////////
   // Synchronisers
   logic [1:0] sda_s_q, req_s_q;
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         sda_s_q <= 2'b11;
         req_s_q <= 2'b11;
      end else begin
         sda_s_q <= {sda_s_q[0], bus.sda};
         req_s_q <= {req_s_q[0], bus.data_request_n};
      end
   end

   ////////////////////////////////////////////////////////////////////
   // Bit engine
   tki_hstate_t st_q;
   logic [15:0] tmr_q;
   logic [3:0]  bit_q;
   logic [8:0]  sh_q;
   logic [7:0]  rx_q;
   logic        nack_q, busy, cmd_go, last_rd_q, is_rd_q, scl_q, sda_q;
   logic [1:0]  cmd_q;
   logic [7:0]  tx_q;
   logic        wait_reply_q;
   logic [31:0] reply_q;
   assign busy   = st_q != TKI_H_IDLE;
   assign cmd_go = psel && penable && pwrite && !busy
                   && paddr == tki_pkg::REG_CTRL;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         st_q      <= TKI_H_IDLE;
         tmr_q     <= 16'h0000;
         bit_q     <= 4'h0;
         sh_q      <= 9'h1ff;
         rx_q      <= 8'h00;
         nack_q    <= 1'b0;
         last_rd_q <= 1'b0;
         is_rd_q   <= 1'b0;
         scl_q     <= 1'b1;
         sda_q     <= 1'b1;
         cmd_q     <= 2'b00;
         wait_reply_q <= 1'b0;
         reply_q   <= 32'h0000_0000;
      end else begin
         tmr_q <= (tmr_q == 16'h0000) ? 16'h0000 : tmr_q - 16'h0001;
         case (st_q)
            TKI_H_IDLE: begin
               if (cmd_go) begin
                  cmd_q     <= pwdata[1:0];
                  last_rd_q <= pwdata[2];
                  tmr_q     <= 16'(tki_pkg::SCL_HALF_CYCLES);
                  bit_q     <= 4'h0;
                  case (tki_pkg::tki_cmd_t'(pwdata[1:0]))
                     tki_pkg::TKI_CMD_START: begin
                        scl_q <= 1'b1;
                        sda_q <= 1'b1;
                        st_q  <= TKI_H_STA;
                     end
                     tki_pkg::TKI_CMD_WRITE: begin
                        sh_q    <= {tx_q, 1'b1};
                        is_rd_q <= 1'b0;
                        st_q    <= TKI_H_BITL;
                     end
                     tki_pkg::TKI_CMD_READ: begin
                        sh_q    <= {8'hff, pwdata[2]};
                        is_rd_q <= 1'b1;
                        st_q    <= TKI_H_BITL;
                     end
                     default: begin
                        sda_q <= 1'b0;
                        st_q  <= TKI_H_STO;
                     end
                  endcase
               end
            end
            TKI_H_STA: begin
               if (tmr_q == 16'h0000) begin
                  if (sda_q) begin
                     sda_q <= 1'b0;
                     tmr_q <= 16'(tki_pkg::SCL_HALF_CYCLES);
                  end else begin
                     scl_q <= 1'b0;
                     st_q  <= TKI_H_IDLE;
                  end
               end
            end
            TKI_H_BITL: begin
               scl_q <= 1'b0;
               if (tmr_q == 16'(tki_pkg::SCL_HALF_CYCLES / 2)) begin
                  sda_q <= sh_q[8];
               end
               if (tmr_q == 16'h0000) begin
                  scl_q <= 1'b1;
                  tmr_q <= 16'(tki_pkg::SCL_HALF_CYCLES);
                  st_q  <= TKI_H_BITH;
               end
            end
            TKI_H_BITH: begin
               if (tmr_q == 16'h0000) begin
                  sh_q  <= {sh_q[7:0], 1'b1};
                  rx_q  <= bit_q < 4'd8 ? {rx_q[6:0], sda_s_q[1]} : rx_q;
                  bit_q <= bit_q + 4'h1;
                  scl_q <= 1'b0;
                  tmr_q <= 16'(tki_pkg::SCL_HALF_CYCLES);
                  if (bit_q == 4'(tki_pkg::PHASE_BITS - 1)) begin
                     nack_q <= sda_s_q[1];
                     st_q   <= TKI_H_IDLE;
                     if (!is_rd_q && tx_q[0] == 1'b0) begin
                        wait_reply_q <= 1'b0;
                     end
                  end else begin
                     st_q <= TKI_H_BITL;
                  end
               end
            end
            TKI_H_STO: begin
               if (tmr_q == 16'h0000) begin
                  if (!scl_q) begin
                     scl_q <= 1'b1;
                     tmr_q <= 16'(tki_pkg::SCL_HALF_CYCLES);
                  end else begin
                     sda_q <= 1'b1;
                     reply_q <= 32'(tki_pkg::REPLY_WAIT_CYCLES);
                     st_q  <= TKI_H_WAIT;
                  end
               end
            end
            default: begin
               // Reply holdoff after each transfer
               if (reply_q == 32'h0000_0000) begin
                  st_q <= TKI_H_IDLE;
               end else begin
                  reply_q <= reply_q - 32'h0000_0001;
               end
            end
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////
   // APB slave
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         tx_q    <= 8'h00;
         prdata  <= 32'h0000_0000;
         pready  <= 1'b0;
         pslverr <= 1'b0;
      end else begin
         pready  <= psel && !penable;
         pslverr <= 1'b0;
         if (psel && !penable) begin
            if (paddr == tki_pkg::REG_TXDATA) begin
               prdata <= {24'h000000, tx_q};
            end else if (paddr == tki_pkg::REG_STATUS) begin
               prdata <= {28'h0000000, !req_s_q[1], nack_q, busy, 1'b0};
            end else if (paddr == tki_pkg::REG_RXDATA) begin
               prdata <= {24'h000000, rx_q};
            end else if (paddr == tki_pkg::REG_CTRL) begin
               prdata <= {29'h0000000, last_rd_q, cmd_q};
            end else begin
               prdata  <= 32'h0000_0000;
               pslverr <= 1'b1;
            end
         end
         if (psel && penable && pwrite && paddr == tki_pkg::REG_TXDATA) begin
            tx_q <= pwdata[7:0];
         end
      end
   end

   assign bus.scl_o       = 1'b0;
   assign bus.scl_oe      = !scl_q;
   assign bus.sda_host_o  = 1'b0;
   assign bus.sda_host_oe = !sda_q;
   assign bus.sel2_level  = 1'b0;
endmodule : tki_host

// ==== dv/tki_chk.sv ====
`timescale 1ns/1ns
module tki_chk (
   input  wire logic pclk,
   input  wire logic presetn,
   input  wire logic scl,
   input  wire logic sda,
   input  wire logic sda_dev_o,
   input  wire logic sda_dev_oe,
   input  wire logic sel2_level
);
   logic        scl_q;
   logic        sda_q;
   logic        xfer_q;
   logic        addr_ph_q;
   logic        rw_q;
   logic        acked_q;
   logic        nack_q;
   logic [3:0]  cnt_q;
   logic [15:0] lvl_q;
   wire rise   = scl && !scl_q;
   wire start  = scl && scl_q && sda_q && !sda;
   wire stop   = scl && scl_q && !sda_q && sda;
   default clocking @(posedge pclk); endclocking
   default disable iff (!presetn);
   ////////////////////////////////////////////////////////////////////////////
   // Line history and level length
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         scl_q <= 1'b1;
         sda_q <= 1'b1;
         lvl_q <= 16'h0;
      end else begin
         scl_q <= scl;
         sda_q <= sda;
         lvl_q <= (scl != scl_q) ? 16'h0 : lvl_q + {15'h0, lvl_q != 16'hffff};
      end
   end
   // Phase tracking
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         xfer_q    <= 1'b0;
         addr_ph_q <= 1'b0;
         rw_q      <= 1'b0;
         acked_q   <= 1'b0;
         nack_q    <= 1'b0;
         cnt_q     <= 4'h0;
      end else if (start) begin
         xfer_q    <= 1'b1;
         addr_ph_q <= 1'b1;
         acked_q   <= 1'b0;
         nack_q    <= 1'b0;
         cnt_q     <= 4'h0;
      end else if (stop) begin
         xfer_q <= 1'b0;
      end else if (rise && xfer_q) begin
         if (cnt_q == 4'h8) begin
            cnt_q     <= 4'h0;
            addr_ph_q <= 1'b0;
            if (addr_ph_q) begin
               acked_q <= sda_dev_oe;
            end else if (rw_q && sda) begin
               nack_q <= 1'b1;
            end
         end else begin
            cnt_q <= cnt_q + 4'h1;
            if (addr_ph_q && cnt_q == 4'h7) begin
               rw_q <= sda;
            end
         end
      end
   end
   ////////////////////////////////////////////////////////////////////////////
   a_scl_low_time: assert property (rise && xfer_q |-> lvl_q >= 16'd470)
      else $error("clock low phase too short");
   a_scl_high_time: assert property (!scl && scl_q && xfer_q |-> lvl_q >= 16'd400)
      else $error("clock high phase too short");
   a_sel2_grounded: assert property (sel2_level == 1'b0)
      else $error("select2 strap not grounded");
   a_open_drain: assert property (sda_dev_oe |-> !sda_dev_o)
      else $error("device drives data high");
   a_sda_scl_low: assert property ($changed(sda_dev_oe) |-> !scl)
      else $error("device data changed with clock high");
   a_addr_ack_bit: assert property (xfer_q && addr_ph_q && rise && sda_dev_oe |-> cnt_q == 4'h8)
      else $error("device drove inside address bits");
   a_silent_other: assert property (xfer_q && !addr_ph_q && !acked_q |-> !sda_dev_oe)
      else $error("device drove in foreign transfer");
   a_write_data_ack: assert property (xfer_q && !addr_ph_q && acked_q && !rw_q && rise && cnt_q == 4'h8 |-> sda_dev_oe)
      else $error("written byte not acknowledged");
   a_read_ack_free: assert property (xfer_q && !addr_ph_q && acked_q && rw_q && rise && cnt_q == 4'h8 |-> !sda_dev_oe)
      else $error("device held data in host ack bit");
   a_nack_release: assert property (nack_q && xfer_q |-> !sda_dev_oe)
      else $error("device drove after not-acknowledge");
endmodule : tki_chk

// ==== dv/testbench.sv ====
`timescale 1ns/1ns
module testbench;
   logic        pclk;
   logic        presetn;
   logic        psel;
   logic        penable;
   logic        pwrite;
   logic [7:0]  paddr;
   logic [31:0] pwdata;
   logic [31:0] prdata;
   logic        pready;
   logic        pslverr;
   logic        power_save_n;
   logic [8:0]  sense_button_pins;
   logic [8:0]  upper_button_in;
   logic        upper_as_output;
   logic        two_wire_selected;
   logic        sleeping;
   logic [7:0]  mem_m [16];
   logic [3:0]  ptr_m;
   logic [6:0]  na;
   logic [31:0] r;
   logic        e;
   int          error_cnt;
   int          total_checks;
   tki_if bus_if ();
   tki_host tki_host_inst (.pclk, .presetn, .bus(bus_if.host), .psel,
      .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr);
   tki_device tki_device_inst (.pclk, .presetn, .bus(bus_if.device),
      .io_protocol_select(1'b0), .power_save_n, .sense_button_pins,
      .upper_button_in, .shared_button_output_pins(), .upper_as_output,
      .two_wire_selected, .sleeping, .direct_mode_sel());
   tki_chk tki_chk_inst (.pclk, .presetn, .scl(bus_if.scl), .sda(bus_if.sda),
      .sda_dev_o(bus_if.sda_dev_o), .sda_dev_oe(bus_if.sda_dev_oe),
      .sel2_level(bus_if.sel2_level));
   initial begin
      pclk = 1'b0;
      forever #5 pclk = ~pclk;
   end
   ////////////////////////////////////////////////////////////////////////////
   task automatic end_of_test();
      $display("checks %0d mismatches %0d", total_checks, error_cnt);
      if (error_cnt == 0 && total_checks > 0) begin
         $display("Regression OK");
      end else begin
         $display("Regression broken");
      end
      $finish;
   endtask : end_of_test
   task automatic chk(input string what, input logic [7:0] exp,
                      input logic [7:0] got);
      total_checks++;
      if (got !== exp) begin
         error_cnt++;
         $display("BAD %s expected %h seen %h", what, exp, got);
      end
   endtask : chk
   task automatic apb(input logic wr, input logic [7:0] a,
                      input logic [31:0] d, output logic [31:0] rd,
                      output logic er);
      int n;
      @(posedge pclk);
      psel   <= 1'b1;
      pwrite <= wr;
      paddr  <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      n = 0;
      do begin
         @(posedge pclk);
         n++;
      end while (pready !== 1'b1 && n < 50);
      if (n >= 50) begin
         error_cnt++;
         end_of_test();
      end
      rd = prdata;
      er = pslverr;
      psel    <= 1'b0;
      penable <= 1'b0;
   endtask : apb
   task automatic cmd(input tki_pkg::tki_cmd_t c, input logic nk,
                      output logic ack);
      logic [31:0] rd;
      logic        er;
      int          n;
      apb(1'b1, tki_pkg::REG_CTRL, {29'h0, nk, c}, rd, er);
      n = 0;
      do begin
         apb(1'b0, tki_pkg::REG_STATUS, 32'h0, rd, er);
         n++;
      end while (rd[1] !== 1'b0 && n < 4000);
      if (n >= 4000) begin
         error_cnt++;
         end_of_test();
      end
      ack = rd[2];
   endtask : cmd
   task automatic wr_byte(input logic [7:0] b, output logic ack);
      logic [31:0] rd;
      logic        er;
      apb(1'b1, tki_pkg::REG_TXDATA, {24'h0, b}, rd, er);
      cmd(tki_pkg::TKI_CMD_WRITE, 1'b0, ack);
   endtask : wr_byte
   task automatic wr_xfer(input logic [6:0] a, input logic [7:0] off,
                          input logic [7:0] dat, input logic nd);
      logic k;
      logic hit;
      hit = (a === mem_m[7][7:1]);
      cmd(tki_pkg::TKI_CMD_START, 1'b0, k);
      wr_byte({a, 1'b0}, k);
      chk("address ack", {7'h0, !hit}, {7'h0, k});
      if (hit) begin
         wr_byte(off, k);
         chk("offset ack", 8'h0, {7'h0, k});
         ptr_m = off[3:0];
         if (nd) begin
            wr_byte(dat, k);
            chk("data ack", 8'h0, {7'h0, k});
            mem_m[ptr_m] = dat;
            ptr_m++;
         end
      end
      cmd(tki_pkg::TKI_CMD_STOP, 1'b0, k);
   endtask : wr_xfer
   task automatic rd_xfer(input logic [6:0] a);
      logic        k;
      logic [31:0] rd;
      logic        er;
      cmd(tki_pkg::TKI_CMD_START, 1'b0, k);
      wr_byte({a, 1'b1}, k);
      chk("read address ack", 8'h0, {7'h0, k});
      cmd(tki_pkg::TKI_CMD_READ, 1'b1, k);
      apb(1'b0, tki_pkg::REG_RXDATA, 32'h0, rd, er);
      chk("read byte", mem_m[ptr_m], rd[7:0]);
      ptr_m++;
      cmd(tki_pkg::TKI_CMD_STOP, 1'b0, k);
   endtask : rd_xfer
   ////////////////////////////////////////////////////////////////////////////
   initial begin
      presetn = 1'b0;
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 8'h00;
      pwdata = 32'h0;
      power_save_n = 1'b1;
      sense_button_pins = 9'h000;
      upper_button_in = 9'h000;
      error_cnt = 0;
      total_checks = 0;
      foreach (mem_m[i]) mem_m[i] = 8'h00;
      mem_m[7] = {tki_pkg::ADDR_RESET, 1'b0};
      ptr_m = 4'h0;
      void'($urandom(32'haf4bf783));
      repeat (5) @(posedge pclk);
      presetn <= 1'b1;
      repeat (4) @(posedge pclk);
      chk("request idle", 8'h1, {7'h0, bus_if.data_request_n});
      chk("two wire", 8'h1, {7'h0, two_wire_selected});
      chk("upper sensing", 8'h0, {7'h0, upper_as_output});
      apb(1'b0, 8'h10, 32'h0, r, e);
      chk("unmapped error", 8'h1, {7'h0, e});
      $display("test straps done");
      na = 7'($urandom_range(127));
      if (na == tki_pkg::ADDR_RESET) na = na ^ 7'h01;
      wr_xfer(na, 8'h07, 8'h00, 1'b0);
      $display("test foreign address done");
      wr_xfer(tki_pkg::ADDR_RESET, tki_pkg::ADDR_REG_OFFSET, {na, 1'b0}, 1'b1);
      $display("test address change done");
      power_save_n <= 1'b0;
      repeat (10) @(posedge pclk);
      chk("sleeping", 8'h1, {7'h0, sleeping});
      sense_button_pins <= 9'($urandom_range(511, 1));
      upper_button_in <= 9'($urandom_range(511));
      repeat (10) @(posedge pclk);
      chk("asleep request", 8'h1, {7'h0, bus_if.data_request_n});
      power_save_n <= 1'b1;
      repeat (10) @(posedge pclk);
      chk("awake", 8'h0, {7'h0, sleeping});
      sense_button_pins <= ~sense_button_pins;
      repeat (10) @(posedge pclk);
      chk("change request", 8'h0, {7'h0, bus_if.data_request_n});
      $display("test sleep and request done");
      wr_xfer(na, tki_pkg::ADDR_REG_OFFSET, 8'h00, 1'b0);
      rd_xfer(na);
      chk("request cleared", 8'h1, {7'h0, bus_if.data_request_n});
      $display("test read back done");
      end_of_test();
   end
endmodule : testbench
